/* design/scr2_pkg.sv */
// Constants shared by the control register two block
//
// Contract
// - Writing 1 to bit 7 copies factory trim from nonvolatile memory into calibration registers.
// - Hardware clears the trim reload bit when the trim copy finishes.
// - Trim reload starts at once on the write, with no other condition.
// - After power-up reset the trim contents are copied automatically.
// - Bit 6 selects interrupt polarity: 0 active high, 1 active low; reset 0.
// - Bit 5 selects interrupt drive: 0 push-pull, 1 open-drain; reset 0.
// - Bit 4 enables register address auto-increment in multi-byte access; reset 1.
// - Writing 1 to bit 2 returns all volatile registers to defaults.
// - Hardware clears the soft register clear bit when the clear completes.
// - Bit 1 selects low-current when 0, low-noise when 1; reset 0.
// - At 100 Hz or 200 Hz the noise bit is ignored, low-current used.
// - Writing 1 to bit 0 starts exactly one pressure and temperature measurement; the code starts it only when sample rate select is 000.
// - On single measurement completion: clear trigger, load outputs, update status.
// - Sample rate select 000 is power-down; other values run continuous acquisition.
// - After a single measurement the device returns to power-down by itself.
// - Codes 110 and 111 are 100 Hz and 200 Hz and disable low-noise.
package scr2_pkg;

  localparam logic [7:0] CONTROL_TWO_ADDR = 8'h11;

  localparam int TRIM_RELOAD_BIT   = 7;
  localparam int IRQ_POLARITY_BIT  = 6;
  localparam int IRQ_DRIVE_BIT     = 5;
  localparam int ADDR_INC_BIT      = 4;
  localparam int SOFT_CLEAR_BIT    = 2;
  localparam int NOISE_MODE_BIT    = 1;
  localparam int SINGLE_CONV_BIT   = 0;

  localparam logic IRQ_POLARITY_RST = 1'b0;
  localparam logic IRQ_DRIVE_RST    = 1'b0;
  localparam logic ADDR_INC_RST     = 1'b1;
  localparam logic NOISE_MODE_RST   = 1'b0;

  localparam logic [2:0] RATE_POWER_DOWN = 3'h0;
  localparam logic [2:0] RATE_100_HZ     = 3'h6;
  localparam logic [2:0] RATE_200_HZ     = 3'h7;

  localparam int CLOCK_PERIOD_NS   = 50;
  localparam int SOFT_CLEAR_TIME_NS = 1000;
  localparam int SOFT_CLEAR_CYCLES =
    (SOFT_CLEAR_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [0:0] {
    SCR2_CONV_IDLE = 1'b0,
    SCR2_CONV_WAIT = 1'b1
  } scr2_conv_state_t;

endpackage

/* design/scr2_trim_loader.sv */
// Copies factory trim words from nonvolatile memory into calibration registers
`timescale 1ns/1ps
`default_nettype none
module scr2_trim_loader #(
  parameter int TRIM_WORDS = 8,
  parameter int TRIM_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                             clock_i,
  input  wire logic                             rst_i,
  // Control
  input  wire logic                             start_i,
  output logic                                  busy_o,
  // Nonvolatile memory read port
  output logic                                  nvm_req_o,
  output logic [$clog2(TRIM_WORDS)-1:0]         nvm_addr_o,
  input  wire logic                             nvm_ack_i,
  input  wire logic [TRIM_WIDTH-1:0]            nvm_data_i,
  // Calibration registers
  output logic [TRIM_WORDS*TRIM_WIDTH-1:0]      trim_o
);
  localparam int AW = $clog2(TRIM_WORDS);
  localparam logic [AW-1:0] LAST_WORD = AW'(TRIM_WORDS - 1);

  logic [TRIM_WIDTH-1:0] trim_mem_ff [TRIM_WORDS];
  logic                  busy_ff;
  logic [AW-1:0]         addr_ff;

  // Reset itself starts the load, so power-up always ends with valid trim
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_ff <= 1'b1;
      addr_ff <= '0;
    end else if (start_i) begin
      busy_ff <= 1'b1;
      addr_ff <= '0;
    end else if (busy_ff && nvm_ack_i) begin
      if (addr_ff == LAST_WORD) begin
        busy_ff <= 1'b0;
      end
      addr_ff <= addr_ff + 1'b1;
    end
  end

  // Trim words are not volatile, so they hold their values across reset
  always_ff @(posedge clock_i) begin
    if (busy_ff && nvm_ack_i) begin
      trim_mem_ff[addr_ff] <= nvm_data_i;
    end
  end

  always_comb begin
    for (int i = 0; i < TRIM_WORDS; i++) begin
      trim_o[i*TRIM_WIDTH +: TRIM_WIDTH] = trim_mem_ff[i];
    end
  end

  assign busy_o     = busy_ff;
  assign nvm_req_o  = busy_ff;
  assign nvm_addr_o = addr_ff;
endmodule
`default_nettype wire

/* design/scr2_control_two.sv */
// Control register two: trim reload, interrupt pad style, soft clear, noise and single conversion
`timescale 1ns/1ps
`default_nettype none
module scr2_control_two #(
  parameter int TRIM_WORDS = 8,
  parameter int TRIM_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                             clock_i,
  input  wire logic                             rst_i,
  // Register port from the serial interface engine
  input  wire logic                             reg_wr_i,
  input  wire logic                             reg_rd_i,
  input  wire logic [7:0]                       reg_addr_i,
  input  wire logic [7:0]                       reg_wdata_i,
  output logic [7:0]                            reg_rdata_o,
  output logic                                  addr_inc_en_o,
  // Sample rate select from control register one
  input  wire logic [2:0]                       sample_rate_select_i,
  // Measurement core
  output logic                                  conv_start_o,
  input  wire logic                             conv_done_i,
  output logic                                  low_noise_o,
  output logic                                  cont_acq_o,
  output logic                                  power_down_o,
  // Volatile register clear to the rest of the register file
  output logic                                  soft_register_clear_o,
  // Interrupt pad
  input  wire logic                             irq_event_i,
  output logic                                  irq_pad_o,
  output logic                                  irq_pad_oe_o,
  // Nonvolatile memory and calibration
  output logic                                  nvm_req_o,
  output logic [$clog2(TRIM_WORDS)-1:0]         nvm_addr_o,
  input  wire logic                             nvm_ack_i,
  input  wire logic [TRIM_WIDTH-1:0]            nvm_data_i,
  output logic [TRIM_WORDS*TRIM_WIDTH-1:0]      trim_o,
  output logic                                  trim_busy_o
);
  localparam int CW = $clog2(scr2_pkg::SOFT_CLEAR_CYCLES + 1);
  localparam logic [CW-1:0] CLEAR_LAST = CW'(scr2_pkg::SOFT_CLEAR_CYCLES - 1);

  logic                        wr_hit;
  logic                        trim_start;
  logic                        trim_busy;
  logic                        irq_polarity_ff;
  logic                        irq_drive_type_ff;
  logic                        addr_inc_ff;
  logic                        noise_mode_ff;
  logic                        clear_busy_ff;
  logic [CW-1:0]               clear_cnt_ff;
  logic                        conv_start_ff;
  scr2_pkg::scr2_conv_state_t  conv_state_ff;
  logic [7:0]                  rdata_ff;
  logic                        low_noise_ff;
  logic                        cont_acq_ff;
  logic                        power_down_ff;
  logic                        irq_pad_ff;
  logic                        irq_pad_oe_ff;
  logic                        irq_level;
  logic                        fast_rate;

  assign wr_hit     = reg_wr_i && (reg_addr_i == scr2_pkg::CONTROL_TWO_ADDR);
  assign trim_start = wr_hit && reg_wdata_i[scr2_pkg::TRIM_RELOAD_BIT];
  assign fast_rate  = (sample_rate_select_i == scr2_pkg::RATE_100_HZ) ||
                      (sample_rate_select_i == scr2_pkg::RATE_200_HZ);

  scr2_trim_loader #(
    .TRIM_WORDS (TRIM_WORDS),
    .TRIM_WIDTH (TRIM_WIDTH)
  ) u_trim (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .start_i    (trim_start),
    .busy_o     (trim_busy),
    .nvm_req_o  (nvm_req_o),
    .nvm_addr_o (nvm_addr_o),
    .nvm_ack_i  (nvm_ack_i),
    .nvm_data_i (nvm_data_i),
    .trim_o     (trim_o)
  );

  // Configuration bits; soft clear puts them back to their defaults
  always_ff @(posedge clock_i) begin
    if (rst_i || clear_busy_ff) begin
      irq_polarity_ff   <= scr2_pkg::IRQ_POLARITY_RST;
      irq_drive_type_ff <= scr2_pkg::IRQ_DRIVE_RST;
      addr_inc_ff       <= scr2_pkg::ADDR_INC_RST;
      noise_mode_ff     <= scr2_pkg::NOISE_MODE_RST;
    end else if (wr_hit) begin
      irq_polarity_ff   <= reg_wdata_i[scr2_pkg::IRQ_POLARITY_BIT];
      irq_drive_type_ff <= reg_wdata_i[scr2_pkg::IRQ_DRIVE_BIT];
      addr_inc_ff       <= reg_wdata_i[scr2_pkg::ADDR_INC_BIT];
      // Changing this outside power-down is the host's fault; we take it anyway
      noise_mode_ff     <= reg_wdata_i[scr2_pkg::NOISE_MODE_BIT];
    end
  end

  // Soft clear runs a fixed number of cycles, then the bit drops by itself
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      clear_busy_ff <= 1'b0;
      clear_cnt_ff  <= '0;
    end else if (clear_busy_ff) begin
      if (clear_cnt_ff == CLEAR_LAST) begin
        clear_busy_ff <= 1'b0;
      end
      clear_cnt_ff <= clear_cnt_ff + 1'b1;
    end else if (wr_hit && reg_wdata_i[scr2_pkg::SOFT_CLEAR_BIT]) begin
      clear_busy_ff <= 1'b1;
      clear_cnt_ff  <= '0;
    end
  end

  // Single conversion; a trigger outside power-down is dropped at once
  always_ff @(posedge clock_i) begin
    if (rst_i || clear_busy_ff) begin
      conv_state_ff <= scr2_pkg::SCR2_CONV_IDLE;
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= 1'b0;
      case (conv_state_ff)
        scr2_pkg::SCR2_CONV_IDLE: begin
          if (wr_hit && reg_wdata_i[scr2_pkg::SINGLE_CONV_BIT] &&
              sample_rate_select_i == scr2_pkg::RATE_POWER_DOWN) begin
            conv_state_ff <= scr2_pkg::SCR2_CONV_WAIT;
            conv_start_ff <= 1'b1;
          end
        end
        scr2_pkg::SCR2_CONV_WAIT: begin
          if (conv_done_i) begin
            conv_state_ff <= scr2_pkg::SCR2_CONV_IDLE;
          end
        end
        default: conv_state_ff <= scr2_pkg::SCR2_CONV_IDLE;
      endcase
    end
  end

  // Mode outputs to the measurement core
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      low_noise_ff  <= 1'b0;
      cont_acq_ff   <= 1'b0;
      power_down_ff <= 1'b1;
    end else begin
      low_noise_ff  <= noise_mode_ff && !fast_rate;
      cont_acq_ff   <= sample_rate_select_i != scr2_pkg::RATE_POWER_DOWN;
      power_down_ff <= (sample_rate_select_i == scr2_pkg::RATE_POWER_DOWN) &&
                       (conv_state_ff == scr2_pkg::SCR2_CONV_IDLE);
    end
  end

  // Interrupt pad: open-drain only pulls low, released otherwise
  assign irq_level = irq_event_i ^ irq_polarity_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_pad_ff    <= 1'b0;
      irq_pad_oe_ff <= 1'b1;
    end else if (irq_drive_type_ff) begin
      irq_pad_ff    <= 1'b0;
      irq_pad_oe_ff <= !irq_level;
    end else begin
      irq_pad_ff    <= irq_level;
      irq_pad_oe_ff <= 1'b1;
    end
  end

  // Read data, registered one cycle after the read strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == scr2_pkg::CONTROL_TWO_ADDR) begin
        rdata_ff <= {trim_busy, irq_polarity_ff, irq_drive_type_ff, addr_inc_ff,
                     1'b0,
                     clear_busy_ff, noise_mode_ff,
                     conv_state_ff == scr2_pkg::SCR2_CONV_WAIT};
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  assign reg_rdata_o           = rdata_ff;
  assign addr_inc_en_o         = addr_inc_ff;
  assign conv_start_o          = conv_start_ff;
  assign low_noise_o           = low_noise_ff;
  assign cont_acq_o            = cont_acq_ff;
  assign power_down_o          = power_down_ff;
  assign soft_register_clear_o = clear_busy_ff;
  assign irq_pad_o             = irq_pad_ff;
  assign irq_pad_oe_o          = irq_pad_oe_ff;
  assign trim_busy_o           = trim_busy;
endmodule
`default_nettype wire

/* bench/scr2_control_two_props.sv */
// Checker for the control register two ports
`timescale 1ns/1ps
`default_nettype none
module scr2_control_two_props #(
  parameter int TRIM_WORDS = 8
) (
  // Clock, reset, register port
  input wire logic                          clock_i, rst_i, reg_wr_i,
  input wire logic [7:0]                    reg_addr_i, reg_wdata_i,
  input wire logic [2:0]                    sample_rate_select_i,
  // Core, clear, pad and trim memory
  input wire logic                          conv_start_o, low_noise_o, cont_acq_o, power_down_o,
  input wire logic                          soft_register_clear_o, irq_event_i, irq_pad_o,
  input wire logic                          irq_pad_oe_o, nvm_req_o, nvm_ack_i, trim_busy_o,
  input wire logic [$clog2(TRIM_WORDS)-1:0] nvm_addr_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic       hit;
  logic [4:0] clr_cnt_ff;
  assign hit = reg_wr_i && reg_addr_i == scr2_pkg::CONTROL_TWO_ADDR;
  // Counts how long the clear pulse stays up
  always_ff @(posedge clock_i) begin
    if (rst_i || !soft_register_clear_o) clr_cnt_ff <= 5'h0;
    else clr_cnt_ff <= clr_cnt_ff + 5'h1;
  end
  property p_trim_start; hit && reg_wdata_i[7] |=> trim_busy_o && nvm_req_o; endproperty
  a_trim_start: assert property (p_trim_start) else $error("trim reload late");
  property p_trim_end; $fell(trim_busy_o) |-> $past(nvm_ack_i) && $past(nvm_addr_o) == TRIM_WORDS-1; endproperty
  a_trim_end: assert property (p_trim_end) else $error("trim busy dropped early");
  property p_one_shot;
    hit && reg_wdata_i[0] && !reg_wdata_i[2] && sample_rate_select_i == 3'h0 && power_down_o
      |=> conv_start_o ##1 (!conv_start_o && !power_down_o);
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("single start wrong");
  property p_shot_refused; hit && sample_rate_select_i != 3'h0 |=> !conv_start_o; endproperty
  a_shot_refused: assert property (p_shot_refused) else $error("start while running");
  property p_fast_rate; sample_rate_select_i >= 3'h6 |=> !low_noise_o; endproperty
  a_fast_rate: assert property (p_fast_rate) else $error("low noise at fast rate");
  property p_cont; 1'b1 |=> cont_acq_o == ($past(sample_rate_select_i) != 3'h0); endproperty
  a_cont: assert property (p_cont) else $error("acquisition mode wrong");
  property p_modes; !(cont_acq_o && power_down_o); endproperty
  a_modes: assert property (p_modes) else $error("run and power-down together");
  property p_pad;
    $changed(irq_event_i) && !$past(reg_wr_i) && !$past(rst_i) |=> $changed({irq_pad_o, irq_pad_oe_o});
  endproperty
  a_pad: assert property (p_pad) else $error("pad missed event");
  property p_clr_start; hit && reg_wdata_i[2] |=> soft_register_clear_o; endproperty
  a_clr_start: assert property (p_clr_start) else $error("clear late");
  property p_clr_len; $fell(soft_register_clear_o) |-> clr_cnt_ff == 5'h14; endproperty
  a_clr_len: assert property (p_clr_len) else $error("clear length wrong");
  c_shot: cover property (conv_start_o);
  c_trim: cover property ($fell(trim_busy_o));
  c_clr: cover property ($fell(soft_register_clear_o));
endmodule
bind scr2_control_two scr2_control_two_props #(.TRIM_WORDS(TRIM_WORDS)) scr2_control_two_props_i (
  .clock_i, .rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .sample_rate_select_i, .conv_start_o,
  .low_noise_o, .cont_acq_o, .power_down_o, .soft_register_clear_o, .irq_event_i, .irq_pad_o,
  .irq_pad_oe_o, .nvm_req_o, .nvm_ack_i, .trim_busy_o, .nvm_addr_o);
`default_nettype wire

/* bench/scr2_far_side_model.sv */
// Trim memory and measurement core facing the control block
`timescale 1ns/1ps
`default_nettype none
module scr2_far_side_model #(
  parameter int TRIM_WORDS  = 8,
  parameter int GAP         = 2,
  parameter int CONV_CYCLES = 6
) (
  input wire logic                          clock_i, rst_i, nvm_req_i, conv_start_i,
  input wire logic [$clog2(TRIM_WORDS)-1:0] nvm_addr_i,
  output logic                              nvm_ack_o, conv_done_o,
  output logic [7:0]                        nvm_data_o
);
  logic       req_d_ff;
  logic [3:0] gen_ff;
  int         wait_q;
  int         conv_q;
  // Each load gets a new generation so a reload is visible in the words
  always_ff @(posedge clock_i) begin
    req_d_ff <= nvm_req_i;
    nvm_ack_o <= 1'b0;
    nvm_data_o <= ~nvm_data_o;
    if (rst_i) begin
      req_d_ff <= 1'b0;
      gen_ff <= 4'h0;
      nvm_data_o <= 8'h00;
      conv_q <= 0;
      conv_done_o <= 1'b0;
    end else begin
      if (nvm_req_i && !req_d_ff) begin
        gen_ff <= gen_ff + 4'h1;
        wait_q <= GAP;
      end else if (nvm_req_i && !nvm_ack_o) begin
        wait_q <= wait_q - 1;
        if (wait_q == 0) begin
          nvm_ack_o <= 1'b1;
          nvm_data_o <= {gen_ff, 4'h0} | 8'(nvm_addr_i);
          wait_q <= GAP;
        end
      end
      if (conv_start_i) conv_q <= CONV_CYCLES;
      else if (conv_q != 0) conv_q <= conv_q - 1;
      conv_done_o <= conv_q == 1;
    end
  end
endmodule
`default_nettype wire

/* bench/scr2_control_two_tb.sv */
// Self-checking bench for control register two
`timescale 1ns/1ps
`default_nettype none
module scr2_control_two_tb;
  typedef struct packed { logic [7:0] wd; logic [2:0] rate; } scr2_row_t;
  logic        clock_i, rst_i, reg_wr_i, reg_rd_i, conv_start_o, conv_done_i, low_noise_o;
  logic        cont_acq_o, power_down_o, soft_register_clear_o, irq_event_i, irq_pad_o;
  logic        irq_pad_oe_o, nvm_req_o, nvm_ack_i, trim_busy_o, addr_inc_en_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, nvm_data_i;
  logic [2:0]  sample_rate_select_i;
  logic [1:0]  nvm_addr_o;
  logic [31:0] trim_o;
  int          fails = 0, comparisons = 0, cycles = 0, i;
  scr2_row_t   rows [6] = '{'{8'h08, 3'h0}, '{8'h52, 3'h0}, '{8'h32, 3'h5},
                            '{8'h72, 3'h6}, '{8'h6A, 3'h7}, '{8'h00, 3'h0}};
  scr2_control_two #(.TRIM_WORDS(4), .TRIM_WIDTH(8)) scr2_control_two_i (.clock_i, .rst_i,
    .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .addr_inc_en_o,
    .sample_rate_select_i, .conv_start_o, .conv_done_i, .low_noise_o, .cont_acq_o, .power_down_o,
    .soft_register_clear_o, .irq_event_i, .irq_pad_o, .irq_pad_oe_o, .nvm_req_o, .nvm_addr_o,
    .nvm_ack_i, .nvm_data_i, .trim_o, .trim_busy_o);
  scr2_far_side_model #(.TRIM_WORDS(4)) scr2_far_side_model_i (.clock_i, .rst_i,
    .nvm_req_i(nvm_req_o), .conv_start_i(conv_start_o), .nvm_addr_i(nvm_addr_o),
    .nvm_ack_o(nvm_ack_i), .conv_done_o(conv_done_i), .nvm_data_o(nvm_data_i));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Whole run is under two hundred cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clock_i);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp, what);
  endtask
  task automatic wait_done(input int lim);
    for (i = 0; i < lim && (trim_busy_o !== 1'b0 || power_down_o !== 1'b1); i++) @(negedge clock_i);
  endtask
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, irq_event_i} = {3'h4, 16'h0, 1'b0};
    sample_rate_select_i = 3'h0;
    repeat (6) @(negedge clock_i);
    rst_i = 1'b0;
    rd(8'h11, 8'h90, "boot load running");
    wait_done(100);
    chk(trim_o, 32'h13121110, "power-up trim");
    $display("test power-up done");
    foreach (rows[k]) begin
      wr(8'h11, rows[k].wd);
      sample_rate_select_i = rows[k].rate;
      // Event moves a cycle after the write so the pad check sees it alone
      @(negedge clock_i);
      irq_event_i = k[0];
      repeat (2) @(negedge clock_i);
      rd(8'h11, rows[k].wd & 8'h72, "readback");
      chk(low_noise_o, rows[k].wd[1] && rows[k].rate < 3'h6, "noise");
      chk({cont_acq_o, power_down_o}, {rows[k].rate != 3'h0, rows[k].rate == 3'h0}, "mode");
      chk(addr_inc_en_o, rows[k].wd[4], "increment");
      chk({irq_pad_o, irq_pad_oe_o}, rows[k].wd[5] ? {1'b0, !(k[0] ^ rows[k].wd[6])}
          : {k[0] ^ rows[k].wd[6], 1'b1}, "pad");
      sample_rate_select_i = 3'h0;
    end
    $display("test rows done");
    wr(8'h11, 8'h90);
    rd(8'h11, 8'h90, "reload busy");
    wait_done(100);
    chk(trim_o, 32'h23222120, "reloaded trim");
    rd(8'h11, 8'h10, "reload cleared");
    $display("test reload done");
    wr(8'h11, 8'h11);
    rd(8'h11, 8'h11, "single pending");
    chk(power_down_o, 1'b0, "busy converting");
    wait_done(50);
    rd(8'h11, 8'h10, "single cleared");
    chk(power_down_o, 1'b1, "back to sleep");
    sample_rate_select_i = 3'h1;
    wr(8'h11, 8'h11);
    rd(8'h11, 8'h10, "start refused");
    sample_rate_select_i = 3'h0;
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00, "other address");
    $display("test single done");
    wr(8'h11, 8'h66);
    rd(8'h11, 8'h14, "clear running");
    repeat (22) @(negedge clock_i);
    rd(8'h11, 8'h10, "clear finished");
    chk(soft_register_clear_o, 1'b0, "clear low");
    wr(8'h11, 8'h62);
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    rd(8'h11, 8'h90, "reset values");
    $display("test clear and reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
